//--- inc/sdc_regs.vh
// Register offsets, field positions, reset values and timing counts of the shock control
`ifndef SDC_REGS_VH
`define SDC_REGS_VH

// ----------------------------------------------------------------
// Clock
// ----------------------------------------------------------------
`define SDC_CLK_KHZ      32'd200000
`define SDC_CLK_MHZ      32'd200

// ----------------------------------------------------------------
// Times as specified, and derived cycle counts
// ----------------------------------------------------------------
`define SDC_T_KEY_MS     32'd150
`define SDC_T_RELAY_MS   32'd100
`define SDC_T_DRIVE_MS   32'd25
`define SDC_T_BLKPER_MS  32'd16
`define SDC_T_BLKON_US   32'd200
`define SDC_T_HOLD_S     32'd20
`define SDC_KEY_CYC      (`SDC_T_KEY_MS * `SDC_CLK_KHZ)
`define SDC_RELAY_CYC    (`SDC_T_RELAY_MS * `SDC_CLK_KHZ)
`define SDC_DRIVE_CYC    (`SDC_T_DRIVE_MS * `SDC_CLK_KHZ)
`define SDC_BLKPER_CYC   (`SDC_T_BLKPER_MS * `SDC_CLK_KHZ)
`define SDC_BLKON_CYC    (`SDC_T_BLKON_US * `SDC_CLK_MHZ)
`define SDC_HOLD_CYC     (`SDC_T_HOLD_S * `SDC_CLK_KHZ * 32'd1000)

// ----------------------------------------------------------------
// Biphasic drive shaping
// ----------------------------------------------------------------
`define SDC_FIRST_ON     16'h00C8
`define SDC_TOFF         16'h0064
`define SDC_TON_BASE     16'h0032
`define SDC_NP1          4'h7
`define SDC_NP2          4'h7
`define SDC_IMP_SCALE    8'h18

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SDC_A_CTRL       8'h00
`define SDC_A_ESEL       8'h04
`define SDC_A_STAT       8'h08
`define SDC_A_EOUT       8'h0C
`define SDC_A_PEAK       8'h10
`define SDC_A_IMP        8'h14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SDC_CTRL_SYNC    0
`define SDC_CTRL_CHARGE  1
`define SDC_CTRL_DISCH   2
`define SDC_STAT_DONE    4
`define SDC_STAT_REFUSE  5

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SDC_ESEL_RST     8'h80

`endif

//--- src/sdc_drive.v
// Phase-one and phase-two switch drive sequencer of the biphasic wave
`include "sdc_regs.vh"

module sdc_drive (
  // Clock and reset
  input  wire        ref_clk_in,
  input  wire        rst_in,
  // Control
  input  wire        start_in,
  input  wire        stop_in,
  input  wire        load_in,
  input  wire [15:0] ton_in,
  input  wire [15:0] toff_in,
  // Drive and status
  output reg         phase_one_drive_out,
  output reg         phase_two_drive_out,
  output reg         first_done_out,
  output wire        first_active_out
);

  localparam [2:0] D_IDLE  = 3'h0;
  localparam [2:0] D_FIRST = 3'h1;
  localparam [2:0] D_WAIT  = 3'h2;
  localparam [2:0] D_P1OFF = 3'h3;
  localparam [2:0] D_P1ON  = 3'h4;
  localparam [2:0] D_P2OFF = 3'h5;
  localparam [2:0] D_P2ON  = 3'h6;

  reg [2:0]  st;
  reg [15:0] cnt;
  reg [3:0]  npul;

  assign first_active_out = (st == D_FIRST);

  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st                  <= D_IDLE;
      cnt                 <= 16'h0000;
      npul                <= 4'h0;
      phase_one_drive_out <= 1'b0;
      phase_two_drive_out <= 1'b0;
      first_done_out      <= 1'b0;
    end else begin
      first_done_out <= 1'b0;
      if (stop_in) begin
        // Relay has opened: the bridge must never be left conducting
        st                  <= D_IDLE;
        phase_one_drive_out <= 1'b0;
        phase_two_drive_out <= 1'b0;
      end else begin
        case (st)
          D_IDLE: begin
            if (start_in) begin
              phase_one_drive_out <= 1'b1;
              cnt                 <= `SDC_FIRST_ON - 16'h0001;
              st                  <= D_FIRST;
            end
          end
          D_FIRST: begin
            if (cnt == 16'h0000) begin
              phase_one_drive_out <= 1'b0;
              first_done_out      <= 1'b1;
              st                  <= D_WAIT;
            end else begin
              cnt <= cnt - 16'h0001;
            end
          end
          D_WAIT: begin
            if (load_in) begin
              cnt  <= toff_in;
              npul <= `SDC_NP1;
              st   <= D_P1OFF;
            end
          end
          D_P1OFF: begin
            if (cnt == 16'h0000) begin
              phase_one_drive_out <= 1'b1;
              cnt                 <= ton_in;
              st                  <= D_P1ON;
            end else begin
              cnt <= cnt - 16'h0001;
            end
          end
          D_P1ON: begin
            if (cnt == 16'h0000) begin
              phase_one_drive_out <= 1'b0;
              cnt                 <= toff_in;
              if (npul == 4'h0) begin
                npul <= `SDC_NP2;
                st   <= D_P2OFF;
              end else begin
                npul <= npul - 4'h1;
                st   <= D_P1OFF;
              end
            end else begin
              cnt <= cnt - 16'h0001;
            end
          end
          D_P2OFF: begin
            if (cnt == 16'h0000) begin
              phase_two_drive_out <= 1'b1;
              cnt                 <= ton_in;
              st                  <= D_P2ON;
            end else begin
              cnt <= cnt - 16'h0001;
            end
          end
          D_P2ON: begin
            if (cnt == 16'h0000) begin
              phase_two_drive_out <= 1'b0;
              cnt                 <= toff_in;
              if (npul == 4'h0) begin
                st <= D_IDLE;
              end else begin
                npul <= npul - 4'h1;
                st   <= D_P2OFF;
              end
            end else begin
              cnt <= cnt - 16'h0001;
            end
          end
          default: st <= D_IDLE;
        endcase
      end
    end
  end

endmodule // sdc_drive

//--- src/sdc_top.v
// Shock delivery control: phase sequencing, relay pulse, drive, measurement, registers
//
// Behaviour
// - Accept shock request only in hold phase
// - Direct mode: key over 150 ms, relay 100 ms
// - Relay pulse needs both triggering channels active
// - Sync mode: relay pulse needs keys plus QRS
// - Sync-mode output high only in synchronised mode
// - First phase-one pulse 25 ms after relay rise
// - Sample peak current during first drive pulse
// - Impedance from capacitor voltage and peak current
// - Drive on durations follow computed impedance; off durations fixed
// - Relay pulse end drops enables, safety discharge
// - Report energy, peak current, impedance to master
// - Check impedance-range input first at key press
// - Out-of-range impedance refuses shock, discharges at once
// - Every safety discharge drops discharge-relay hold
// - Shock enable held throughout hold phase
// - Blocking pulses during charge and hold phases
// - Stop HV generator when charge energy reached
// - Blocking pulses every 16 ms, 200 us long
// - No shock within 20 s of hold: discharge
`include "sdc_regs.vh"

module sdc_top #(
  parameter [31:0] KEY_CYC    = `SDC_KEY_CYC,
  parameter [31:0] RELAY_CYC  = `SDC_RELAY_CYC,
  parameter [31:0] DRIVE_CYC  = `SDC_DRIVE_CYC,
  parameter [31:0] BLKPER_CYC = `SDC_BLKPER_CYC,
  parameter [31:0] BLKON_CYC  = `SDC_BLKON_CYC,
  parameter [31:0] HOLD_CYC   = `SDC_HOLD_CYC
) (
  // Clock and reset
  input  wire        ref_clk_in,
  input  wire        rst_in,
  // Register port from the master processor link
  input  wire [7:0]  reg_addr_in,
  input  wire [15:0] reg_wdata_in,
  input  wire        reg_wr_in,
  input  wire        reg_rd_in,
  output reg  [15:0] reg_rdata_out,
  // Key, sync and fault inputs
  input  wire        shock_key_line_in,
  input  wire        shock_key_detect_n_in,
  input  wire        qrs_trigger_n_in,
  input  wire        impedance_in_range_n_in,
  input  wire        fault_latch_in,
  // Measurements
  input  wire [7:0]  cap_voltage_meas_in,
  input  wire [7:0]  charge_voltage_meas_in,
  input  wire [7:0]  peak_current_meas_in,
  // High-voltage controls
  output reg         patient_relay_pulse_out,
  output reg         sync_mode_out,
  output reg         shock_enable_out,
  output reg         discharge_relay_hold_out,
  output reg         hv_supply_enable_out,
  output reg         hv_generator_run_out,
  output reg         phase_one_block_out,
  output reg         phase_two_block_out,
  output wire        phase_one_drive_out,
  output wire        phase_two_drive_out
);

  // ----------------------------------------------------------------
  // Phases
  // ----------------------------------------------------------------
  localparam [2:0] P_IDLE   = 3'h0;
  localparam [2:0] P_CHARGE = 3'h1;
  localparam [2:0] P_HOLD   = 3'h2;
  localparam [2:0] P_SHOCK  = 3'h3;
  localparam [2:0] P_DISCH  = 3'h4;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  reg [4:0]  bit_s1;
  reg [4:0]  bit_s2;
  reg [23:0] meas_s1;
  reg [23:0] meas_s2;

  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      bit_s1  <= 5'h1F;
      bit_s2  <= 5'h1F;
      meas_s1 <= 24'h000000;
      meas_s2 <= 24'h000000;
    end else begin
      bit_s1  <= {~fault_latch_in, impedance_in_range_n_in, qrs_trigger_n_in,
                  shock_key_detect_n_in, shock_key_line_in};
      bit_s2  <= bit_s1;
      meas_s1 <= {peak_current_meas_in, charge_voltage_meas_in, cap_voltage_meas_in};
      meas_s2 <= meas_s1;
    end
  end

  wire       key_line_low = ~bit_s2[0];
  wire       key_active   = ~bit_s2[1];
  wire       qrs_pulse    = ~bit_s2[2];
  wire       imp_in_range = bit_s2[3];
  wire       fault        = ~bit_s2[4];
  wire [7:0] cap_v        = meas_s2[7:0];
  wire [7:0] chg_v        = meas_s2[15:8];
  wire [7:0] ipk          = meas_s2[23:16];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg        sync_mode;
  reg [7:0]  energy_sel;
  reg        done_flag;
  reg        refuse_flag;
  reg [7:0]  energy_out;
  reg [7:0]  peak_out;
  reg [15:0] imp_out;
  reg [2:0]  phase;

  wire wr_ctrl   = reg_wr_in && (reg_addr_in == `SDC_A_CTRL);
  wire cmd_chg   = wr_ctrl && reg_wdata_in[`SDC_CTRL_CHARGE];
  wire cmd_dis   = wr_ctrl && reg_wdata_in[`SDC_CTRL_DISCH];
  wire wr_stat   = reg_wr_in && (reg_addr_in == `SDC_A_STAT);
  wire set_done;
  wire set_refuse;

  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync_mode     <= 1'b0;
      energy_sel    <= `SDC_ESEL_RST;
      done_flag     <= 1'b0;
      refuse_flag   <= 1'b0;
      reg_rdata_out <= 16'h0000;
    end else begin
      if (wr_ctrl) begin
        sync_mode <= reg_wdata_in[`SDC_CTRL_SYNC];
      end
      if (reg_wr_in && (reg_addr_in == `SDC_A_ESEL)) begin
        energy_sel <= reg_wdata_in[7:0];
      end
      // A hardware set in the clearing cycle wins
      if (set_done) begin
        done_flag <= 1'b1;
      end else if (wr_stat && reg_wdata_in[`SDC_STAT_DONE]) begin
        done_flag <= 1'b0;
      end
      if (set_refuse) begin
        refuse_flag <= 1'b1;
      end else if (wr_stat && reg_wdata_in[`SDC_STAT_REFUSE]) begin
        refuse_flag <= 1'b0;
      end
      reg_rdata_out <= 16'h0000;
      if (reg_rd_in) begin
        if (reg_addr_in == `SDC_A_CTRL) begin
          reg_rdata_out <= {15'h0000, sync_mode};
        end else if (reg_addr_in == `SDC_A_ESEL) begin
          reg_rdata_out <= {8'h00, energy_sel};
        end else if (reg_addr_in == `SDC_A_STAT) begin
          reg_rdata_out <= {10'h000, refuse_flag, done_flag, 1'b0, phase};
        end else if (reg_addr_in == `SDC_A_EOUT) begin
          reg_rdata_out <= {8'h00, energy_out};
        end else if (reg_addr_in == `SDC_A_PEAK) begin
          reg_rdata_out <= {8'h00, peak_out};
        end else if (reg_addr_in == `SDC_A_IMP) begin
          reg_rdata_out <= imp_out;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Energy and impedance arithmetic
  // ----------------------------------------------------------------
  // Stored energy scales with the square of the voltage; top byte kept
  wire [15:0] chg_sq   = chg_v * chg_v;
  wire [15:0] cap_sq   = cap_v * cap_v;
  wire [15:0] imp_num  = cap_v * `SDC_IMP_SCALE;
  wire [7:0]  imp_den  = (peak_out == 8'h00) ? 8'h01 : peak_out;
  wire [15:0] imp_calc = imp_num / {8'h00, imp_den};

  // ----------------------------------------------------------------
  // Key qualification and phase sequencing
  // ----------------------------------------------------------------
  reg [31:0] key_cnt;
  reg [31:0] ph_cnt;
  reg        key_prev;
  reg        drv_start;
  reg        drv_load;
  reg [15:0] ton;
  reg        first_prev;
  reg        done_pulse;
  reg        refuse_pulse;

  wire drv_first;
  wire drv_first_done;
  wire key_press = key_active && !key_prev;
  wire direct_go = !sync_mode && (key_cnt == KEY_CYC);
  wire sync_go   = sync_mode && key_active && qrs_pulse;
  wire abort     = fault || cmd_dis;

  assign set_done   = done_pulse;
  assign set_refuse = refuse_pulse;

  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      phase                    <= P_IDLE;
      key_cnt                  <= 32'h00000000;
      ph_cnt                   <= 32'h00000000;
      key_prev                 <= 1'b0;
      drv_start                <= 1'b0;
      drv_load                 <= 1'b0;
      ton                      <= `SDC_TON_BASE;
      first_prev               <= 1'b0;
      done_pulse               <= 1'b0;
      refuse_pulse             <= 1'b0;
      energy_out               <= 8'h00;
      peak_out                 <= 8'h00;
      imp_out                  <= 16'h0000;
      patient_relay_pulse_out  <= 1'b0;
      sync_mode_out            <= 1'b0;
      shock_enable_out         <= 1'b0;
      discharge_relay_hold_out <= 1'b0;
      hv_supply_enable_out     <= 1'b0;
      hv_generator_run_out     <= 1'b0;
    end else begin
      key_prev      <= key_active;
      drv_start     <= 1'b0;
      drv_load      <= 1'b0;
      done_pulse    <= 1'b0;
      refuse_pulse  <= 1'b0;
      first_prev    <= drv_first;
      sync_mode_out <= sync_mode;
      // Key held time counts only in hold, saturating past the threshold
      if (phase == P_HOLD && key_active && key_cnt <= KEY_CYC) begin
        key_cnt <= key_cnt + 32'h00000001;
      end else if (!key_active || phase != P_HOLD) begin
        key_cnt <= 32'h00000000;
      end
      if (abort && phase != P_IDLE) begin
        phase <= P_DISCH;
      end else begin
        case (phase)
          P_IDLE: begin
            if (cmd_chg) begin
              phase                    <= P_CHARGE;
              ph_cnt                   <= 32'h00000000;
              hv_supply_enable_out     <= 1'b1;
              discharge_relay_hold_out <= 1'b1;
              hv_generator_run_out     <= 1'b1;
            end
          end
          P_CHARGE: begin
            if (chg_sq[15:8] >= energy_sel) begin
              hv_generator_run_out <= 1'b0;
              shock_enable_out     <= 1'b1;
              ph_cnt               <= 32'h00000000;
              phase                <= P_HOLD;
            end
          end
          P_HOLD: begin
            ph_cnt <= ph_cnt + 32'h00000001;
            if (ph_cnt == HOLD_CYC - 32'h00000001) begin
              phase <= P_DISCH;
            end else if (key_press && !imp_in_range) begin
              refuse_pulse <= 1'b1;
              phase        <= P_DISCH;
            end else if (key_line_low && !key_press && (direct_go || sync_go)) begin
              patient_relay_pulse_out <= 1'b1;
              energy_out              <= cap_sq[15:8];
              peak_out                <= 8'h00;
              ph_cnt                  <= 32'h00000000;
              phase                   <= P_SHOCK;
            end
          end
          P_SHOCK: begin
            ph_cnt <= ph_cnt + 32'h00000001;
            if (ph_cnt == DRIVE_CYC - 32'h00000001) begin
              drv_start <= 1'b1;
            end
            if (drv_first && ipk > peak_out) begin
              peak_out <= ipk;
            end
            if (drv_first_done) begin
              imp_out  <= imp_calc;
              ton      <= `SDC_TON_BASE - 16'h0001 + {imp_calc[13:0], 2'b00};
              drv_load <= 1'b1;
            end
            if (ph_cnt == RELAY_CYC - 32'h00000001) begin
              done_pulse <= 1'b1;
              phase      <= P_DISCH;
            end
          end
          P_DISCH: begin
            phase <= P_IDLE;
          end
          default: phase <= P_IDLE;
        endcase
      end
      if ((abort && phase != P_IDLE) || phase == P_DISCH || phase == P_IDLE && !cmd_chg) begin
        patient_relay_pulse_out  <= 1'b0;
        shock_enable_out         <= 1'b0;
        discharge_relay_hold_out <= 1'b0;
        hv_supply_enable_out     <= 1'b0;
        hv_generator_run_out     <= 1'b0;
      end
      if (phase == P_SHOCK && ph_cnt == RELAY_CYC - 32'h00000001) begin
        patient_relay_pulse_out  <= 1'b0;
        shock_enable_out         <= 1'b0;
        discharge_relay_hold_out <= 1'b0;
        hv_supply_enable_out     <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bridge blocking pulses
  // ----------------------------------------------------------------
  reg [31:0] blk_cnt;

  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      blk_cnt             <= 32'h00000000;
      phase_one_block_out <= 1'b0;
      phase_two_block_out <= 1'b0;
    end else if (phase == P_CHARGE || phase == P_HOLD) begin
      blk_cnt             <= (blk_cnt == BLKPER_CYC - 32'h00000001) ?
                             32'h00000000 : blk_cnt + 32'h00000001;
      phase_one_block_out <= (blk_cnt < BLKON_CYC);
      phase_two_block_out <= (blk_cnt < BLKON_CYC);
    end else begin
      blk_cnt             <= 32'h00000000;
      phase_one_block_out <= 1'b0;
      phase_two_block_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Biphasic drive
  // ----------------------------------------------------------------
  sdc_drive u_drive (
    .ref_clk_in          (ref_clk_in),
    .rst_in              (rst_in),
    .start_in            (drv_start),
    .stop_in             (phase != P_SHOCK),
    .load_in             (drv_load),
    .ton_in              (ton),
    .toff_in             (`SDC_TOFF - 16'h0001),
    .phase_one_drive_out (phase_one_drive_out),
    .phase_two_drive_out (phase_two_drive_out),
    .first_done_out      (drv_first_done),
    .first_active_out    (drv_first)
  );

endmodule // sdc_top

//--- dv/sdc_master.sv
// Register-link master model standing in for the main processor
module sdc_master (
  // Clock
  input  wire         ref_clk_in,
  // Register port
  output logic [7:0]  reg_addr_out,
  output logic [15:0] reg_wdata_out,
  output logic        reg_wr_out,
  output logic        reg_rd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_addr_out = 8'h00;
    reg_wdata_out = 16'h0000;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk_in);
    reg_addr_out <= a;
    reg_wdata_out <= d;
    reg_wr_out <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_out <= 1'b0;
    reg_addr_out <= ~a;
    reg_wdata_out <= ~d;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk_in);
    reg_addr_out <= a;
    reg_rd_out <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_out <= 1'b0;
    reg_addr_out <= ~a;
  endtask
endmodule // sdc_master

//--- dv/sdc_properties.sv
// Concurrent checks on the shock delivery control ports
module sdc_properties #(
  parameter int DRIVE_CYC = 100
) (
  // Clock and reset
  input wire        ref_clk_in,
  input wire        rst_in,
  // Register port and fault
  input wire [7:0]  reg_addr_in,
  input wire [15:0] reg_wdata_in,
  input wire        reg_wr_in,
  input wire        reg_rd_in,
  input wire [15:0] reg_rdata_out,
  input wire        fault_latch_in,
  // Outputs
  input wire        patient_relay_pulse_out,
  input wire        sync_mode_out,
  input wire        shock_enable_out,
  input wire        discharge_relay_hold_out,
  input wire        hv_supply_enable_out,
  input wire        hv_generator_run_out,
  input wire        phase_one_block_out,
  input wire        phase_two_block_out,
  input wire        phase_one_drive_out
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DLO = DRIVE_CYC - 2;
  localparam int DHI = DRIVE_CYC + 2;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  a_relay_from_hold: assert property (
    $rose(patient_relay_pulse_out) |-> $past(shock_enable_out)) else $error("relay outside hold");
  a_end_discharge: assert property (
    $fell(patient_relay_pulse_out) |-> !shock_enable_out && !discharge_relay_hold_out
      && !hv_supply_enable_out) else $error("enables stay after relay");
  a_sync_follows: assert property (
    reg_wr_in && reg_addr_in == 8'h00 |-> ##2 sync_mode_out == $past(reg_wdata_in[0], 2))
    else $error("sync mode wrong");
  a_rdata_idle: assert property (
    !$past(reg_rd_in) |-> reg_rdata_out == 16'h0000) else $error("read data not idle");
  a_block_width: assert property (
    $rose(phase_one_block_out) |-> (phase_one_block_out[*8] ##1 !phase_one_block_out)
      or ##[0:8] (patient_relay_pulse_out || !hv_supply_enable_out))
    else $error("block width wrong");
  a_blocks_paired: assert property (
    phase_one_block_out == phase_two_block_out) else $error("blocks differ");
  a_no_block_shock: assert property (
    patient_relay_pulse_out && $past(patient_relay_pulse_out) |-> !phase_one_block_out)
    else $error("block during shock");
  a_run_charging: assert property (
    hv_generator_run_out |-> hv_supply_enable_out && discharge_relay_hold_out
      && !shock_enable_out) else $error("run outside charge");
  a_first_drive: assert property (
    $rose(patient_relay_pulse_out) |-> ##[DLO:DHI] phase_one_drive_out)
    else $error("first drive late");
  a_fault_discharge: assert property (
    fault_latch_in |-> ##[1:5] !discharge_relay_hold_out) else $error("fault kept hold");
  a_hold_enable: assert property (
    shock_enable_out |-> discharge_relay_hold_out && hv_supply_enable_out)
    else $error("enable without hold");
endmodule // sdc_properties

bind sdc_top sdc_properties #(.DRIVE_CYC(DRIVE_CYC)) u_props (.ref_clk_in(ref_clk_in),
  .rst_in(rst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .fault_latch_in(fault_latch_in), .patient_relay_pulse_out(patient_relay_pulse_out),
  .sync_mode_out(sync_mode_out), .shock_enable_out(shock_enable_out),
  .discharge_relay_hold_out(discharge_relay_hold_out),
  .hv_supply_enable_out(hv_supply_enable_out), .hv_generator_run_out(hv_generator_run_out),
  .phase_one_block_out(phase_one_block_out), .phase_two_block_out(phase_two_block_out),
  .phase_one_drive_out(phase_one_drive_out));

//--- dv/shock_delivery_control_test.sv
// Self-checking bench for the shock delivery control
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin n_mismatch++; \
  $display("unexpected %s exp %0h got %0h", nm, ex, gt); end end
`define WAITC(c, n) for (int k = 0; k < (n) && !(c); k++) begin @(posedge clk); #1; end
module shock_delivery_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int KC = 20, RC = 2000, DC = 100, HC = 5000;
  logic        clk, rst, kline, kdet_n, qrs_n, rng_n, fault, rd_q, wr, rd;
  logic        relay, sync, sh_en, hold, hv_en, run, b1, b2, d1, d2;
  logic [7:0]  addr, cap, chg, pk;
  logic [15:0] wdata, rdata, e;
  logic [15:0] q[$];
  int          n_mismatch = 0, n_checks = 0;
  sdc_top #(.KEY_CYC(KC), .RELAY_CYC(RC), .DRIVE_CYC(DC), .BLKPER_CYC(64), .BLKON_CYC(8),
    .HOLD_CYC(HC)) dut (.ref_clk_in(clk), .rst_in(rst), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .shock_key_line_in(kline), .shock_key_detect_n_in(kdet_n), .qrs_trigger_n_in(qrs_n),
    .impedance_in_range_n_in(rng_n), .fault_latch_in(fault), .cap_voltage_meas_in(cap),
    .charge_voltage_meas_in(chg), .peak_current_meas_in(pk), .patient_relay_pulse_out(relay),
    .sync_mode_out(sync), .shock_enable_out(sh_en), .discharge_relay_hold_out(hold),
    .hv_supply_enable_out(hv_en), .hv_generator_run_out(run), .phase_one_block_out(b1),
    .phase_two_block_out(b2), .phase_one_drive_out(d1), .phase_two_drive_out(d2));
  sdc_master u_m (.ref_clk_in(clk), .reg_addr_out(addr), .reg_wdata_out(wdata),
    .reg_wr_out(wr), .reg_rd_out(rd));
  // ----
  // Tasks and watchers
  // ----
  task automatic wrap_up();
    if (n_mismatch == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] ex);
    q.push_back(ex);
    u_m.rd(a);
  endtask
  task automatic to_hold(input logic s);
    int c;
    logic [7:0] en;
    en = 8'($urandom_range(1, 60));
    for (c = 0; ((c * c) >> 8) < en; c++);
    chg <= 8'(c - 1);
    u_m.wr(8'h04, {8'h00, en});
    u_m.wr(8'h00, {14'h0000, 1'b1, s});
    repeat (8) @(posedge clk);
    #1 `CHK("run", 1'b1, run)
    chg <= 8'(c);
    `WAITC(sh_en, 10)
    `CHK("run", 1'b0, run)
    `CHK("enable", 1'b1, sh_en)
    rd_chk(8'h08, 16'h0002);
  endtask
  always @(posedge clk) begin
    if (rd_q) begin
      e = q.pop_front();
      `CHK("rdata", e, rdata)
    end
    rd_q <= rd;
  end
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Run is near 9300 cycles; the 40000-cycle limit, over four times that, is a hang
  initial begin
    #200000;
    n_mismatch++;
    wrap_up();
  end
  initial begin
    int t, w, dd, r, w2, m;
    logic p;
    rst = 1'b1; kline = 1'b1; kdet_n = 1'b1; qrs_n = 1'b1; rng_n = 1'b1; fault = 1'b0;
    cap = 8'h00; chg = 8'h00; pk = 8'h00;
    void'($urandom(64076));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd_chk(8'h04, 16'h0080);
    rd_chk(8'h20, 16'h0000);
    u_m.wr(8'h20, 16'hFFFF);
    rd_chk(8'h08, 16'h0000);
    kline <= 1'b0; kdet_n <= 1'b0;
    repeat (KC + 20) @(posedge clk);
    #1 `CHK("relay", 1'b0, relay)
    kline <= 1'b1; kdet_n <= 1'b1;
    cap <= 8'($urandom_range(50, 120));
    pk <= 8'($urandom_range(100, 255));
    to_hold(1'b0);
    kline <= 1'b0; kdet_n <= 1'b0;
    for (t = 0; t < KC + 20 && !relay; t++) begin @(posedge clk); #1; end
    `CHK("key time", 1'b1, t > KC && t < KC + 8)
    w = 0; dd = 0; r = 0; w2 = 0; p = 1'b0;
    while (relay && w < RC + 20) begin
      if (d1 && !p) r++;
      if (d1 && dd == 0) dd = w;
      if (d1 && r == 2) w2++;
      p = d1;
      w++;
      @(posedge clk);
      #1;
    end
    `CHK("width", RC, w)
    `CHK("drive", 1'b1, dd >= DC - 2 && dd <= DC + 2)
    `CHK("ton", 50 + 4 * (int'(cap) * 24 / int'(pk)), w2)
    `CHK("off", 5'h00, {sh_en, hold, hv_en, d1, d2})
    kline <= 1'b1; kdet_n <= 1'b1;
    rd_chk(8'h10, {8'h00, pk});
    rd_chk(8'h14, 16'(int'(cap) * 24 / int'(pk)));
    rd_chk(8'h08, 16'h0010);
    u_m.wr(8'h08, 16'h0030);
    to_hold(1'b0);
    rng_n <= 1'b0;
    kline <= 1'b0; kdet_n <= 1'b0;
    `WAITC(!hold, 10)
    `CHK("hold", 1'b0, hold)
    repeat (KC + 10) @(posedge clk);
    #1 `CHK("relay", 1'b0, relay)
    kline <= 1'b1; kdet_n <= 1'b1; rng_n <= 1'b1;
    rd_chk(8'h08, 16'h0020);
    u_m.wr(8'h08, 16'h0030);
    to_hold(1'b1);
    `CHK("sync", 1'b1, sync)
    kline <= 1'b0; kdet_n <= 1'b0;
    repeat (KC + 20) @(posedge clk);
    #1 `CHK("relay", 1'b0, relay)
    qrs_n <= 1'b0;
    `WAITC(relay, KC + 20)
    `CHK("relay", 1'b1, relay)
    qrs_n <= 1'b1;
    `WAITC(!relay, RC + 20)
    kline <= 1'b1; kdet_n <= 1'b1;
    u_m.wr(8'h00, 16'h0000);
    u_m.wr(8'h08, 16'h0030);
    for (m = 0; m < 3; m++) begin
      to_hold(1'b0);
      if (m == 1) u_m.wr(8'h00, 16'h0004);
      if (m == 2) fault <= 1'b1;
      `WAITC(!hold, m ? 10 : HC + 20)
      `CHK("hold", 1'b0, hold)
      fault <= 1'b0;
    end
    repeat (10) @(posedge clk);
    wrap_up();
  end
endmodule // shock_delivery_control_test
